/* File: logic/nvsram_host_defines.vh */
/*
  Constants for the host controller of a byte-wide static memory with
  nonvolatile backup: pin timings, command codes, software sequence addresses.
  Assumes a 125 MHz system clock; all counts derive from the clock period.
*/
`ifndef NVSRAM_HOST_DEFINES_VH
`define NVSRAM_HOST_DEFINES_VH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define NV_CLK_PS 8000

// ----------------------------------------------------------------------------
// times as printed, in their own units
// ----------------------------------------------------------------------------
`define NV_T_CYCLE_NS 25
`define NV_T_HW_PULSE_NS 15
`define NV_T_NOWRITE_NS 25
`define NV_T_SS_US 100
`define NV_T_RECALL_US 200
`define NV_T_STORE_MS 8
`define NV_T_PWR_RECALL_MS 20

// ----------------------------------------------------------------------------
// cycle counts: least times round up, longest times round down
// ----------------------------------------------------------------------------
`define NV_UP(ps) (((ps) + `NV_CLK_PS - 1) / `NV_CLK_PS)
`define NV_DN(ps) (((ps) / `NV_CLK_PS) < 1 ? 1 : ((ps) / `NV_CLK_PS))
`define NV_CYCLE_CYC `NV_UP(`NV_T_CYCLE_NS * 1000)
`define NV_HW_PULSE_CYC `NV_UP(`NV_T_HW_PULSE_NS * 1000)
`define NV_NOWRITE_CYC `NV_UP(`NV_T_NOWRITE_NS * 1000)
`define NV_SS_CYC `NV_DN(`NV_T_SS_US * 1000000)
`define NV_RECALL_CYC `NV_DN(`NV_T_RECALL_US * 1000000)
// millisecond figures divide first: the picosecond product would overflow 32 bits
`define NV_PS_PER_MS 1000000000
`define NV_STORE_CYC (`NV_T_STORE_MS * (`NV_PS_PER_MS / `NV_CLK_PS))
`define NV_PWR_RECALL_CYC (`NV_T_PWR_RECALL_MS * (`NV_PS_PER_MS / `NV_CLK_PS))

// ----------------------------------------------------------------------------
// command codes on cmd_op_i
// ----------------------------------------------------------------------------
`define NV_OP_READ 3'h0
`define NV_OP_WRITE 3'h1
`define NV_OP_SW_STORE 3'h2
`define NV_OP_SW_RECALL 3'h3
`define NV_OP_HW_STORE 3'h4

// ----------------------------------------------------------------------------
// software sequence addresses, first read in the low 15 bits (plain defaults)
// ----------------------------------------------------------------------------
`define NV_SEQ_STORE_DEF {15'h0005, 15'h0004, 15'h0003, 15'h0002, 15'h0001, 15'h0000}
`define NV_SEQ_RECALL_DEF {15'h000B, 15'h000A, 15'h0009, 15'h0008, 15'h0007, 15'h0006}

`endif

/* File: logic/wait_timer.v */
/*
  Down-counting wait timer: load a count, expired is high once it reaches zero.
  Assumes one clock domain and a clock enable that freezes the count.
*/
`timescale 1ns/1ps

module wait_timer #(
  parameter W = 32
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire load_i,
  input wire [W-1:0] value_i,
  output wire expired_o
);

  reg [W-1:0] count_q;

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= {W{1'b0}};
    end else if (ce_i) begin
      if (load_i) begin
        count_q <= value_i;
      end else if (count_q != {W{1'b0}}) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  assign expired_o = (count_q == {W{1'b0}});

endmodule // wait_timer

/* File: logic/nvsram_host.v */
/*
  Host controller for an asynchronous byte-wide static memory with
  nonvolatile backup: read, write, software save/restore sequences and
  pulse-started save, with busy-line supervision.
  Assumes device pins are synchronous to clk_i; the store busy line is
  open drain with an external pull-up resolved by the surroundings.
*/
`timescale 1ns/1ps
`include "nvsram_host_defines.vh"

module nvsram_host #(
  parameter AW = 15,
  parameter TW = 32,
  parameter [TW-1:0] SS_CYC = `NV_SS_CYC,
  parameter [TW-1:0] RECALL_CYC = `NV_RECALL_CYC,
  parameter [TW-1:0] STORE_CYC = `NV_STORE_CYC,
  parameter [TW-1:0] PWR_RECALL_CYC = `NV_PWR_RECALL_CYC,
  parameter [6*AW-1:0] SEQ_STORE = `NV_SEQ_STORE_DEF,
  parameter [6*AW-1:0] SEQ_RECALL = `NV_SEQ_RECALL_DEF
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire power_ok_i,
  input wire cmd_valid_i,
  input wire [2:0] cmd_op_i,
  input wire [AW-1:0] cmd_addr_i,
  input wire [7:0] cmd_wdata_i,
  output reg cmd_ready_o,
  output reg done_o,
  output reg error_o,
  output reg [7:0] rdata_o,
  output reg chip_sel_n_o,
  output reg write_n_o,
  output reg out_gate_n_o,
  output reg [AW-1:0] addr_o,
  output reg [7:0] dq_o,
  output reg dq_oe_o,
  input wire [7:0] dq_i,
  input wire store_busy_line_i,
  output reg store_busy_line_o,
  output reg store_busy_line_oe_o
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [7:0] ST_PWRUP = 8'h01;
  localparam [7:0] ST_IDLE = 8'h02;
  localparam [7:0] ST_ACT = 8'h04;
  localparam [7:0] ST_HOLD = 8'h08;
  localparam [7:0] ST_PULSE = 8'h10;
  localparam [7:0] ST_SETTLE = 8'h20;
  localparam [7:0] ST_WAIT = 8'h40;
  localparam [7:0] ST_BUSY = 8'h80;

  localparam [TW-1:0] CYCLE_CYC = `NV_CYCLE_CYC;
  localparam [TW-1:0] PULSE_CYC = `NV_HW_PULSE_CYC;
  localparam [TW-1:0] NOWRITE_CYC = `NV_NOWRITE_CYC;

  // sequence address for step idx of a save or restore command
  function [AW-1:0] seq_addr;
    input recall;
    input [2:0] idx;
    reg [6*AW-1:0] tbl;
    begin
      tbl = recall ? SEQ_RECALL : SEQ_STORE;
      seq_addr = tbl[idx*AW +: AW];
    end
  endfunction

  reg [7:0] state_q;
  reg [2:0] op_q;
  reg [2:0] seq_idx_q;
  reg tmr_load_q;
  reg [TW-1:0] tmr_val_q;
  reg fault_q;
  wire tmr_expired;
  wire tmr_done;
  wire port_free;

  wait_timer #(
    .W(TW)
  ) u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .load_i(tmr_load_q),
    .value_i(tmr_val_q),
    .expired_o(tmr_expired)
  );

  // a load takes effect one edge late, so the stale zero is masked
  assign tmr_done = tmr_expired & ~tmr_load_q;
  // device ignores cycles while busy or supply is low
  assign port_free = store_busy_line_i & power_ok_i;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_PWRUP;
      op_q <= `NV_OP_READ;
      seq_idx_q <= 3'h0;
      tmr_load_q <= 1'b1;
      tmr_val_q <= PWR_RECALL_CYC;
      fault_q <= 1'b0;
      cmd_ready_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
      rdata_o <= 8'h00;
      chip_sel_n_o <= 1'b1;
      write_n_o <= 1'b1;
      out_gate_n_o <= 1'b1;
      addr_o <= {AW{1'b0}};
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
      store_busy_line_o <= 1'b0;
      store_busy_line_oe_o <= 1'b0;
    end else if (ce_i) begin
      tmr_load_q <= 1'b0;
      done_o <= 1'b0;
      case (state_q)
        // power-up restore: wait the longest restore time and the busy line
        ST_PWRUP: begin
          if (tmr_done && port_free) begin
            state_q <= ST_IDLE;
            cmd_ready_o <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (cmd_valid_i && cmd_ready_o && port_free) begin
            cmd_ready_o <= 1'b0;
            op_q <= cmd_op_i;
            seq_idx_q <= 3'h0;
            fault_q <= 1'b0;
            tmr_load_q <= 1'b1;
            if (cmd_op_i == `NV_OP_HW_STORE) begin
              tmr_val_q <= PULSE_CYC;
              store_busy_line_oe_o <= 1'b1;
              state_q <= ST_PULSE;
            end else begin
              tmr_val_q <= CYCLE_CYC;
              chip_sel_n_o <= 1'b0;
              if (cmd_op_i == `NV_OP_WRITE) begin
                addr_o <= cmd_addr_i;
                write_n_o <= 1'b0;
                dq_o <= cmd_wdata_i;
                dq_oe_o <= 1'b1;
              end else begin
                // sequence reads keep the write strobe high throughout
                addr_o <= (cmd_op_i == `NV_OP_READ) ? cmd_addr_i
                          : seq_addr(cmd_op_i == `NV_OP_SW_RECALL, 3'h0);
                out_gate_n_o <= 1'b0;
              end
              state_q <= ST_ACT;
            end
          end
        end
        ST_ACT: begin
          if (!store_busy_line_i) begin
            fault_q <= 1'b1;
          end
          if (tmr_done) begin
            if (op_q != `NV_OP_WRITE && seq_idx_q != 3'h5) begin
              rdata_o <= dq_i;
            end
            // select rises with the strobes; address holds one more cycle
            chip_sel_n_o <= 1'b1;
            write_n_o <= 1'b1;
            out_gate_n_o <= 1'b1;
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          dq_oe_o <= 1'b0;
          if (op_q == `NV_OP_SW_STORE || op_q == `NV_OP_SW_RECALL) begin
            if (seq_idx_q == 3'h5) begin
              tmr_load_q <= 1'b1;
              tmr_val_q <= (op_q == `NV_OP_SW_RECALL) ? SS_CYC + RECALL_CYC : SS_CYC;
              state_q <= ST_WAIT;
            end else if (port_free) begin
              // address moves only with select high, never during a strobe
              seq_idx_q <= seq_idx_q + 3'h1;
              addr_o <= seq_addr(op_q == `NV_OP_SW_RECALL, seq_idx_q + 3'h1);
              chip_sel_n_o <= 1'b0;
              out_gate_n_o <= 1'b0;
              tmr_load_q <= 1'b1;
              tmr_val_q <= CYCLE_CYC;
              state_q <= ST_ACT;
            end else begin
              fault_q <= 1'b1;
              tmr_load_q <= 1'b1;
              tmr_val_q <= STORE_CYC;
              state_q <= ST_BUSY;
            end
          end else begin
            done_o <= 1'b1;
            error_o <= fault_q;
            cmd_ready_o <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_PULSE: begin
          if (tmr_done) begin
            store_busy_line_oe_o <= 1'b0;
            tmr_load_q <= 1'b1;
            tmr_val_q <= NOWRITE_CYC;
            state_q <= ST_SETTLE;
          end
        end
        // let the device either take the line low or release it again
        ST_SETTLE: begin
          if (tmr_done) begin
            tmr_load_q <= 1'b1;
            tmr_val_q <= STORE_CYC;
            state_q <= ST_BUSY;
          end
        end
        ST_WAIT: begin
          if (tmr_done) begin
            tmr_load_q <= 1'b1;
            tmr_val_q <= STORE_CYC;
            state_q <= ST_BUSY;
          end
        end
        // the device may drive the line high briefly, then the pull-up holds it
        ST_BUSY: begin
          if (port_free || tmr_done) begin
            done_o <= 1'b1;
            error_o <= fault_q | ~port_free;
            cmd_ready_o <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cmd_ready_o <= 1'b1;
          chip_sel_n_o <= 1'b1;
          write_n_o <= 1'b1;
          out_gate_n_o <= 1'b1;
          dq_oe_o <= 1'b0;
          store_busy_line_oe_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // nvsram_host

/* File: dv/nvsram_host_props.sv */
/* checker for the host pin sequencing of nvsram_host
   assumes it sees only the top module ports, one clock domain */
`timescale 1ns/1ps
module nvsram_host_props #(
  parameter AW = 15
) (
  input wire clk_i,
  input wire reset_i,
  input wire power_ok_i,
  input wire cmd_ready_o,
  input wire chip_sel_n_o,
  input wire write_n_o,
  input wire out_gate_n_o,
  input wire [AW-1:0] addr_o,
  input wire dq_oe_o,
  input wire store_busy_line_i,
  input wire store_busy_line_oe_o
);
  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_read_act;
    (!chip_sel_n_o && !out_gate_n_o) [*6];
  endsequence
  sequence s_pulse;
    store_busy_line_oe_o [*4] ##1 !store_busy_line_oe_o;
  endsequence
  a_read_frame: assert property ($fell(chip_sel_n_o) && !out_gate_n_o |-> s_read_act ##1 chip_sel_n_o)
    else $error("read frame not six cycles");
  a_pulse_width: assert property ($rose(store_busy_line_oe_o) |-> s_pulse)
    else $error("busy pulse not four cycles");
  a_addr_hold: assert property (!chip_sel_n_o && !$past(chip_sel_n_o) |-> $stable(addr_o))
    else $error("address moved while selected");
  a_read_we_high: assert property (!out_gate_n_o |-> write_n_o)
    else $error("write strobe low in read");
  a_write_drive: assert property ($fell(write_n_o) |-> !chip_sel_n_o && dq_oe_o && out_gate_n_o)
    else $error("write without data drive");
  a_no_pull_access: assert property (!chip_sel_n_o |-> !store_busy_line_oe_o)
    else $error("busy pulled during access");
  a_busy_no_start: assert property (cmd_ready_o && chip_sel_n_o && !(store_busy_line_i && power_ok_i)
    |=> chip_sel_n_o)
    else $error("access started while busy");
endmodule // nvsram_host_props

bind nvsram_host nvsram_host_props #(.AW(AW)) u_props (.clk_i(clk_i), .reset_i(reset_i),
  .power_ok_i(power_ok_i), .cmd_ready_o(cmd_ready_o), .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o),
  .out_gate_n_o(out_gate_n_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o), .store_busy_line_i(store_busy_line_i),
  .store_busy_line_oe_o(store_busy_line_oe_o));

/* File: dv/nv_device_model.sv */
/* behavioural model of the backed-up static memory seen by the host
   assumes pins change only at clock edges; busy line has a pull-up outside */
`timescale 1ns/1ps
module nv_device_model (
  input wire clk_i,
  input wire chip_sel_n_i,
  input wire write_n_i,
  input wire out_gate_n_i,
  input wire [14:0] addr_i,
  input wire [7:0] dq_i,
  input wire power_ok_i,
  input wire host_pull_i,
  input wire [7:0] busy_len_i,
  output reg [7:0] dq_o,
  output reg dq_oe_o,
  output wire busy_pull_o
);
  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg [7:0] mem [0:32767];
  reg [7:0] busy_q = 8'h00;
  reg [2:0] step_q = 3'h0;
  reg [14:0] a_q = 15'h0000;
  reg [14:0] nxt_q = 15'h0000;
  reg dirty_q = 1'b0;
  reg pull_q = 1'b0;
  reg cs_q = 1'b1;
  reg rd_q = 1'b0;
  wire idle = busy_q == 8'h00 && power_ok_i;
  wire hit = a_q == nxt_q && step_q != 3'h0;
  // only pulls low, never drives high, so the pull-up ends every busy phase
  assign busy_pull_o = !idle;
  initial dq_o = 8'h5A;
  always @(posedge clk_i) begin
    cs_q <= chip_sel_n_i;
    pull_q <= host_pull_i;
    rd_q <= !chip_sel_n_i && write_n_i;
    a_q <= addr_i;
    dq_oe_o <= idle && !chip_sel_n_i && write_n_i && !out_gate_n_i && step_q != 3'h5;
    // released bus shows the inverse of the last value, never a held copy
    dq_o <= (idle && !chip_sel_n_i && write_n_i && !out_gate_n_i && step_q != 3'h5) ? mem[addr_i] : ~dq_o;
    // a write under way while a save pulse is held still lands
    if (idle && !chip_sel_n_i && !write_n_i) begin
      mem[addr_i] <= dq_i;
      dirty_q <= 1'b1;
    end
    if (busy_q != 8'h00) busy_q <= busy_q - 8'h01;
    if (pull_q && !host_pull_i && dirty_q) begin
      busy_q <= busy_len_i;
      dirty_q <= 1'b0;
    end
    if (idle && chip_sel_n_i && !cs_q && rd_q) begin
      nxt_q <= a_q + 15'h0001;
      if (hit) step_q <= step_q + 3'h1;
      else step_q <= (a_q == 15'h0000 || a_q == 15'h0006) ? 3'h1 : 3'h0;
      if (hit && step_q == 3'h5) begin
        busy_q <= busy_len_i;
        step_q <= 3'h0;
      end
    end
    if (!power_ok_i) begin
      busy_q <= busy_len_i;
      dirty_q <= 1'b0;
    end
  end
endmodule // nv_device_model

/* File: dv/tb_nvsram_host.sv */
/* self-checking bench for nvsram_host against the device model
   assumes 125 MHz clock and shortened save and restore counts */
`timescale 1ns/1ps
`include "nvsram_host_defines.vh"
module tb_nvsram_host;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg power_ok_i = 1'b1;
  reg cmd_valid_i = 1'b0;
  reg [2:0] cmd_op_i = 3'h0;
  reg [14:0] cmd_addr_i = 15'h0000;
  reg [7:0] cmd_wdata_i = 8'h00;
  reg [7:0] busy_len = 8'h03;
  wire cmd_ready_o, done_o, error_o, chip_sel_n_o, write_n_o, out_gate_n_o, dq_oe_o, sb_o, sb_oe_o, dev_pull;
  wire [7:0] rdata_o, dq_o, dev_dq;
  wire [14:0] addr_o;
  wire store_busy_line_i = !(sb_oe_o || dev_pull);
  integer n_mismatch = 0, tests_run = 0, seed = 32, i, k, t;
  reg ok;
  reg [9:0] e;
  reg [9:0] exp_q [$];
  reg [14:0] ad [0:7];
  reg [7:0] dv [0:7];
  // ----------------------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------------------
  initial forever #4 clk_i = !clk_i;
  nvsram_host #(.SS_CYC(32'd20), .RECALL_CYC(32'd30), .STORE_CYC(32'd50), .PWR_RECALL_CYC(32'd10)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .power_ok_i(power_ok_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .error_o(error_o), .rdata_o(rdata_o), .chip_sel_n_o(chip_sel_n_o), .write_n_o(write_n_o),
    .out_gate_n_o(out_gate_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dev_dq),
    .store_busy_line_i(store_busy_line_i), .store_busy_line_o(sb_o), .store_busy_line_oe_o(sb_oe_o));
  nv_device_model u_dev (.clk_i(clk_i), .chip_sel_n_i(chip_sel_n_o), .write_n_i(write_n_o),
    .out_gate_n_i(out_gate_n_o), .addr_i(addr_o), .dq_i(dq_o), .power_ok_i(power_ok_i), .host_pull_i(sb_oe_o),
    .busy_len_i(busy_len), .dq_o(dev_dq), .dq_oe_o(), .busy_pull_o(dev_pull));
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task check(input string nm, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  // e: bit 9 compare read data, bit 8 expected error flag, low byte data
  task cmd(input [2:0] op, input [14:0] a, input [7:0] d, input [9:0] ex);
    begin
      exp_q.push_back(ex);
      cmd_op_i = op;
      cmd_addr_i = a;
      cmd_wdata_i = d;
      cmd_valid_i = 1'b1;
      ok = 1'b0;
      for (t = 0; t < 3000 && !ok; t = t + 1) begin
        ok = cmd_ready_o === 1'b1 && store_busy_line_i === 1'b1 && power_ok_i;
        @(posedge clk_i);
        #1;
      end
      cmd_valid_i = 1'b0;
      // let an edge pass so a following call never re-raises valid in this step
      @(posedge clk_i);
      #1;
      if (!ok) begin
        check("take", 8'h01, 8'h00);
        complete_run;
      end
    end
  endtask
  task drain;
    begin
      for (t = 0; t < 3000 && exp_q.size() != 0; t = t + 1) @(posedge clk_i);
      #1;
      if (exp_q.size() != 0) begin
        check("drain", 8'h00, 8'h01);
        complete_run;
      end
    end
  endtask
  // ----------------------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------------------
  // outputs are looked at mid-cycle, where the one-cycle done pulse has settled
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) check("extra done", 8'h00, 8'h01);
      else begin
        e = exp_q.pop_front();
        check("error", {7'h00, e[8]}, {7'h00, error_o});
        if (e[9]) check("rdata", e[7:0], rdata_o);
      end
    end
  end
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      // distinct per index and clear of the sequence addresses
      ad[i] = {7'($random(seed)), i[2:0], 5'h10};
      dv[i] = 8'($random(seed));
      cmd(`NV_OP_WRITE, ad[i], dv[i], 10'h000);
    end
    for (i = 0; i < 8; i = i + 1) cmd(`NV_OP_READ, ad[i], 8'h00, {2'b10, dv[i]});
    $display("test read write done");
    for (k = 0; k < 2; k = k + 1) begin
      busy_len = k ? 8'd40 : 8'd3;
      cmd(`NV_OP_SW_STORE, 15'h0000, 8'h00, 10'h000);
      cmd(`NV_OP_SW_RECALL, 15'h0000, 8'h00, 10'h000);
      cmd(`NV_OP_READ, ad[k], 8'h00, {2'b10, dv[k]});
    end
    $display("test software sequence done");
    cmd(`NV_OP_WRITE, ad[2], 8'hA5, 10'h000);
    cmd(`NV_OP_HW_STORE, 15'h0000, 8'h00, 10'h000);
    cmd(`NV_OP_HW_STORE, 15'h0000, 8'h00, 10'h000);
    cmd(`NV_OP_WRITE, ad[3], 8'h3C, 10'h000);
    busy_len = 8'd90;
    cmd(`NV_OP_HW_STORE, 15'h0000, 8'h00, 10'h100);
    cmd(`NV_OP_READ, ad[2], 8'h00, 10'h2A5);
    $display("test pulse save done");
    drain;
    busy_len = 8'd3;
    power_ok_i = 1'b0;
    fork
      begin
        repeat (20) @(posedge clk_i);
        #1 power_ok_i = 1'b1;
      end
      cmd(`NV_OP_READ, ad[3], 8'h00, 10'h23C);
    join
    $display("test power loss done");
    drain;
    reset_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 reset_i = 1'b0;
    cmd(`NV_OP_READ, ad[4], 8'h00, {2'b10, dv[4]});
    drain;
    $display("test second reset done");
    complete_run;
  end
endmodule // tb_nvsram_host
